// File: common/resl_defs.svh
// constants for the receiver event status latches
//
// Overview of operation
// [RL1] each flag sets on its event and holds until its clear bit is used; the vendor flag takes the mpeg clear
// [RL2] a flag counts only while its first-line mask bit is set; software ignores others
// [RL3] mpeg source frame checksum error latches bit 7 at 0x89, reset 0
// [RL4] product descriptor frame checksum error latches bit 6 at 0x89, reset 0
// [RL5] audio frame checksum error latches bit 5 at 0x89, reset 0
// [RL6] video frame checksum error latches bit 4 at 0x89, reset 0
// [RL7] link check value expiry on first port latches bit 2 at 0x89
// [RL8] remote key register write on first port latches bit 0 at 0x89
// [RL9] background measurements ready latches bit 1 at 0x8e; zero while unfinished
// [RL10] vendor frame checksum error latches bit 0 at 0x8e, cleared by mpeg clear
// [RL11] read-only 8-bit opcode event byte at 0x98, one bit per watched opcode
// [RL12] separate control flags: three rx buffers ready, retry timeout, arbitration lost, tx done
// [RL13] status registers are read-only; writes never alter any flag
// [RL14] bits 3 and 1 at 0x89 read zero and ignore writes
// [RL15] clear resets flag at once; an event in the same cycle wins
`ifndef RESL_DEFS_SVH
`define RESL_DEFS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define RESL_OFS_FRAME_STATUS 8'h89
`define RESL_OFS_MEASURE_STATUS 8'h8e
`define RESL_OFS_CONTROL_STATUS 8'h97
`define RESL_OFS_OPCODE_BYTE 8'h98

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define RESL_POS_MPEG 7
`define RESL_POS_PRODUCT 6
`define RESL_POS_AUDIO 5
`define RESL_POS_VIDEO 4
`define RESL_POS_LINK 2
`define RESL_POS_KEY 0
`define RESL_POS_MEASURE 1
`define RESL_POS_VENDOR 0
`define RESL_POS_RX0 0
`define RESL_POS_RX1 1
`define RESL_POS_RX2 2
`define RESL_POS_RETRY 3
`define RESL_POS_ARBITRATION 4
`define RESL_POS_TX_DONE 5

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define RESL_RST_BYTE 8'h00
`define RESL_RST_FLAGS 22'h000000

`endif

// File: common/resl_pkg.sv
// types shared by the receiver event status latches
package resl_pkg;

    // one-cycle event pulses, also the layout of latched and masked flags
    typedef struct packed {
        logic mpeg_frame_checksum;
        logic product_frame_checksum;
        logic audio_frame_checksum;
        logic video_frame_checksum;
        logic link_check_expired;
        logic key_write_seen;
        logic background_measure_done;
        logic vendor_frame_checksum;
        logic [2:0] control_rx_buffer_ready;
        logic control_tx_retry_timeout;
        logic control_tx_arbitration_lost;
        logic control_tx_done;
        logic [7:0] control_opcode_event_bits;
    } resl_evt_type;

    // clear pulses; the vendor frame flag shares the mpeg clear
    typedef struct packed {
        logic mpeg_frame_checksum_clear;
        logic product_frame_checksum_clear;
        logic audio_frame_checksum_clear;
        logic video_frame_checksum_clear;
        logic link_check_expired_clear;
        logic key_write_seen_clear;
        logic background_measure_done_clear;
        logic [2:0] control_rx_buffer_ready_clear;
        logic control_tx_retry_timeout_clear;
        logic control_tx_arbitration_lost_clear;
        logic control_tx_done_clear;
        logic [7:0] control_opcode_event_clear;
    } resl_clr_type;

    // register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } resl_req_type;

    // the four readable status bytes
    typedef struct packed {
        logic [7:0] frame_status;
        logic [7:0] measure_status;
        logic [7:0] control_status;
        logic [7:0] opcode_byte;
    } resl_bytes_type;

endpackage

// File: hw/resl_flag_bank.sv
// bank of sticky event flags with set-over-clear priority
`timescale 1ns/1ps
`include "resl_defs.svh"

module resl_flag_bank
    import resl_pkg::*;
#(
    parameter int WIDTH = 22
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // set wins over clear, otherwise hold
    always_comb begin
        flags_next = set | (flags_reg & ~clr); // [RL1] [RL15]
    end

    // flag storage, cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= WIDTH'(`RESL_RST_FLAGS);
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule

// File: hw/resl_reg_port.sv
// read-only register port over the status bytes
`timescale 1ns/1ps
`include "resl_defs.svh"

module resl_reg_port
    import resl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire resl_req_type req,
    input wire resl_bytes_type bytes_in,
    output logic [7:0] rdata,
    output logic ack
);

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic ack_reg;
    logic ack_next;

    // address decode; unmapped reads return zero, write data is dropped
    always_comb begin
        ack_next = req.rd | req.wr; // [RL13]
        rdata_next = rdata_reg;
        if (req.rd) begin
            case (req.addr)
                `RESL_OFS_FRAME_STATUS: rdata_next = bytes_in.frame_status;
                `RESL_OFS_MEASURE_STATUS: rdata_next = bytes_in.measure_status;
                `RESL_OFS_CONTROL_STATUS: rdata_next = bytes_in.control_status;
                `RESL_OFS_OPCODE_BYTE: rdata_next = bytes_in.opcode_byte; // [RL11]
                default: rdata_next = `RESL_RST_BYTE;
            endcase
        end
    end

    // answer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `RESL_RST_BYTE;
            ack_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    assign rdata = rdata_reg;
    assign ack = ack_reg;

endmodule

// File: hw/resl_top.sv
// top of the receiver event status latches
`timescale 1ns/1ps
`include "resl_defs.svh"

module resl_top
    import resl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire resl_evt_type EVT,
    input wire resl_clr_type CLR,
    input wire resl_evt_type MASK,
    input wire resl_req_type REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_ACK,
    output resl_evt_type VALID_FLAGS,
    output logic ANY_VALID
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ------------------------------------------------------------------
    // set and clear vectors
    // ------------------------------------------------------------------

    resl_evt_type set_vec;
    resl_evt_type clr_vec;
    resl_evt_type flag_vec;

    // event pulses drive the set side of each latch
    always_comb begin
        set_vec = EVT;
        set_vec.mpeg_frame_checksum = EVT.mpeg_frame_checksum; // [RL3]
        set_vec.product_frame_checksum = EVT.product_frame_checksum; // [RL4]
        set_vec.audio_frame_checksum = EVT.audio_frame_checksum; // [RL5]
        set_vec.video_frame_checksum = EVT.video_frame_checksum; // [RL6]
        set_vec.link_check_expired = EVT.link_check_expired; // [RL7]
        set_vec.key_write_seen = EVT.key_write_seen; // [RL8]
        set_vec.background_measure_done = EVT.background_measure_done; // [RL9]
        set_vec.vendor_frame_checksum = EVT.vendor_frame_checksum; // [RL10]
        set_vec.control_rx_buffer_ready = EVT.control_rx_buffer_ready; // [RL12]
        set_vec.control_tx_retry_timeout = EVT.control_tx_retry_timeout; // [RL12]
        set_vec.control_tx_arbitration_lost = EVT.control_tx_arbitration_lost; // [RL12]
        set_vec.control_tx_done = EVT.control_tx_done; // [RL12]
        set_vec.control_opcode_event_bits = EVT.control_opcode_event_bits; // [RL11]
    end

    // each flag takes its own clear bit, except vendor, which takes the mpeg clear; only clear pulses reach this side
    always_comb begin
        clr_vec = '0;
        clr_vec.mpeg_frame_checksum = CLR.mpeg_frame_checksum_clear; // [RL1]
        clr_vec.product_frame_checksum = CLR.product_frame_checksum_clear; // [RL1]
        clr_vec.audio_frame_checksum = CLR.audio_frame_checksum_clear; // [RL1]
        clr_vec.video_frame_checksum = CLR.video_frame_checksum_clear; // [RL1]
        clr_vec.link_check_expired = CLR.link_check_expired_clear; // [RL1]
        clr_vec.key_write_seen = CLR.key_write_seen_clear; // [RL1]
        clr_vec.background_measure_done = CLR.background_measure_done_clear; // [RL1]
        clr_vec.vendor_frame_checksum = CLR.mpeg_frame_checksum_clear; // [RL10]
        clr_vec.control_rx_buffer_ready = CLR.control_rx_buffer_ready_clear; // [RL1]
        clr_vec.control_tx_retry_timeout = CLR.control_tx_retry_timeout_clear; // [RL1]
        clr_vec.control_tx_arbitration_lost = CLR.control_tx_arbitration_lost_clear; // [RL1]
        clr_vec.control_tx_done = CLR.control_tx_done_clear; // [RL1]
        clr_vec.control_opcode_event_bits = CLR.control_opcode_event_clear; // [RL1]
    end

    // ------------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------------

    // one bank holds every flag; register writes never reach it
    resl_flag_bank #(
        .WIDTH($bits(resl_evt_type))
    ) u_flags (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .set(set_vec),
        .clr(clr_vec),
        .flags(flag_vec)
    ); // [RL13] [RL15]

    // ------------------------------------------------------------------
    // status bytes
    // ------------------------------------------------------------------

    resl_bytes_type bytes_vec;
    logic mpeg_frame_checksum_flag;
    logic product_frame_checksum_flag;
    logic audio_frame_checksum_flag;
    logic video_frame_checksum_flag;
    logic link_check_expired_flag;
    logic key_write_seen_flag;
    logic background_measure_done_flag;
    logic vendor_frame_checksum_flag;

    // named views of the latched flags
    assign mpeg_frame_checksum_flag = flag_vec.mpeg_frame_checksum;
    assign product_frame_checksum_flag = flag_vec.product_frame_checksum;
    assign audio_frame_checksum_flag = flag_vec.audio_frame_checksum;
    assign video_frame_checksum_flag = flag_vec.video_frame_checksum;
    assign link_check_expired_flag = flag_vec.link_check_expired;
    assign key_write_seen_flag = flag_vec.key_write_seen;
    assign background_measure_done_flag = flag_vec.background_measure_done;
    assign vendor_frame_checksum_flag = flag_vec.vendor_frame_checksum;

    // place the flags at their bit positions; unused bits stay zero
    always_comb begin
        bytes_vec = '0; // [RL14]
        bytes_vec.frame_status[`RESL_POS_MPEG] = mpeg_frame_checksum_flag; // [RL3]
        bytes_vec.frame_status[`RESL_POS_PRODUCT] = product_frame_checksum_flag; // [RL4]
        bytes_vec.frame_status[`RESL_POS_AUDIO] = audio_frame_checksum_flag; // [RL5]
        bytes_vec.frame_status[`RESL_POS_VIDEO] = video_frame_checksum_flag; // [RL6]
        bytes_vec.frame_status[`RESL_POS_LINK] = link_check_expired_flag; // [RL7]
        bytes_vec.frame_status[`RESL_POS_KEY] = key_write_seen_flag; // [RL8]
        bytes_vec.measure_status[`RESL_POS_MEASURE] = background_measure_done_flag; // [RL9]
        bytes_vec.measure_status[`RESL_POS_VENDOR] = vendor_frame_checksum_flag; // [RL10]
        bytes_vec.control_status[`RESL_POS_RX0] = flag_vec.control_rx_buffer_ready[0]; // [RL12]
        bytes_vec.control_status[`RESL_POS_RX1] = flag_vec.control_rx_buffer_ready[1]; // [RL12]
        bytes_vec.control_status[`RESL_POS_RX2] = flag_vec.control_rx_buffer_ready[2]; // [RL12]
        bytes_vec.control_status[`RESL_POS_RETRY] = flag_vec.control_tx_retry_timeout; // [RL12]
        bytes_vec.control_status[`RESL_POS_ARBITRATION] = flag_vec.control_tx_arbitration_lost; // [RL12]
        bytes_vec.control_status[`RESL_POS_TX_DONE] = flag_vec.control_tx_done; // [RL12]
        bytes_vec.opcode_byte = flag_vec.control_opcode_event_bits; // [RL11]
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------

    logic [7:0] port_rdata;
    logic port_ack;

    // reads only; writes are acknowledged and discarded
    resl_reg_port u_port (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .req(REG_REQ),
        .bytes_in(bytes_vec),
        .rdata(port_rdata),
        .ack(port_ack)
    ); // [RL13]

    assign REG_RDATA = port_rdata;
    assign REG_ACK = port_ack;

    // ------------------------------------------------------------------
    // mask qualification
    // ------------------------------------------------------------------

    resl_evt_type valid_reg;
    resl_evt_type valid_next;
    logic any_reg;
    logic any_next;

    // a flag is reported only while its mask bit enables it
    always_comb begin
        valid_next = flag_vec & MASK; // [RL2]
        any_next = |valid_next; // [RL2]
    end

    // registered qualified flags
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= resl_evt_type'(`RESL_RST_FLAGS);
            any_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            any_reg <= any_next;
        end
    end

    assign VALID_FLAGS = valid_reg;
    assign ANY_VALID = any_reg;

endmodule

// File: bench/resl_chk.sv
// port assertions for the status latch top
`timescale 1ns/1ps

module resl_chk
    import resl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire resl_evt_type EVT,
    input wire resl_clr_type CLR,
    input wire resl_evt_type MASK,
    input wire resl_req_type REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire resl_evt_type VALID_FLAGS,
    input wire logic ANY_VALID
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    // register port handshake and read data
    chk_ack_follows: assert property ((REG_REQ.rd || REG_REQ.wr) |=> REG_ACK)
        else $error("no acknowledge after request");
    chk_ack_single: assert property (!(REG_REQ.rd || REG_REQ.wr) |=> !REG_ACK)
        else $error("acknowledge without request");
    chk_rsvd_zero: assert property (
        (REG_REQ.rd && REG_REQ.addr == 8'h89) |=> (REG_RDATA[3] == 1'b0 && REG_RDATA[1] == 1'b0))
        else $error("reserved bit read nonzero");
    chk_read_key: assert property (
        EVT.key_write_seen ##1 (REG_REQ.rd && REG_REQ.addr == 8'h89) |=> REG_RDATA[0])
        else $error("key write flag not read back");

    // flag latching seen through the masked outputs
    chk_mask_gates: assert property (1'b1 |=> ((VALID_FLAGS & ~$past(MASK)) == 22'h000000))
        else $error("masked flag shown as valid");
    chk_any_or: assert property (ANY_VALID == (VALID_FLAGS != 22'h000000))
        else $error("summary line disagrees with flags");
    chk_set_shows: assert property (EVT.key_write_seen ##1 MASK.key_write_seen |=> VALID_FLAGS.key_write_seen)
        else $error("event did not latch");
    chk_set_wins: assert property (
        (EVT.link_check_expired && CLR.link_check_expired_clear) ##1 MASK.link_check_expired
        |=> VALID_FLAGS.link_check_expired)
        else $error("clear beat a same-cycle event");
    chk_clear_drops: assert property (
        (CLR.key_write_seen_clear && !EVT.key_write_seen) |=> ##1 !VALID_FLAGS.key_write_seen)
        else $error("clear did not drop flag");
    chk_vendor_holds: assert property (
        (VALID_FLAGS.vendor_frame_checksum && MASK.vendor_frame_checksum && !$past(CLR.mpeg_frame_checksum_clear))
        |=> VALID_FLAGS.vendor_frame_checksum)
        else $error("vendor flag lost without its clear");
endmodule

bind resl_top resl_chk resl_chk_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .EVT(EVT), .CLR(CLR), .MASK(MASK),
    .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .VALID_FLAGS(VALID_FLAGS), .ANY_VALID(ANY_VALID));

// File: bench/resl_host.sv
// host software model on the register port
`timescale 1ns/1ps

module resl_host
    import resl_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic ack,
    output resl_req_type req
);
    initial req = '0;

    // one strobe; answer taken one cycle later, then one idle edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
            output logic [7:0] got, output logic seen);
        req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1 req = '0;
        seen = (ack === 1'b1);
        got = rdata;
        @(posedge clk);
        #1;
    endtask

    // software heeds a latched bit only where its mask bit is set
    function automatic resl_evt_type heed(input resl_evt_type flags, input resl_evt_type mask);
        return flags & mask;
    endfunction
endmodule

// File: bench/receiver_event_status_latches_bench.sv
// self-checking bench for the status latches
`timescale 1ns/1ps

module receiver_event_status_latches_bench
    import resl_pkg::*;
;
    logic clk;
    logic nrst;
    resl_evt_type evt;
    resl_evt_type mask;
    resl_evt_type valid;
    resl_clr_type clr;
    resl_req_type req;
    logic [7:0] rdata;
    logic [7:0] got;
    logic ack;
    logic any_valid;
    logic seen;
    logic [21:0] model;
    int miscompares;
    int n_checks;
    int it;

    resl_top resl_top_inst (.CORE_CLK(clk), .NRST(nrst), .EVT(evt), .CLR(clr), .MASK(mask), .REG_REQ(req),
        .REG_RDATA(rdata), .REG_ACK(ack), .VALID_FLAGS(valid), .ANY_VALID(any_valid));
    resl_host resl_host_inst (.clk(clk), .rdata(rdata), .ack(ack), .req(req));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // expected byte at an offset from the flag model
    function automatic logic [7:0] exp_rd(input logic [21:0] f, input logic [7:0] a);
        case (a)
            8'h89: return {f[21:18], 1'b0, f[17], 1'b0, f[16]};
            8'h8e: return {6'h00, f[15:14]};
            8'h97: return {2'b00, f[8], f[9], f[10], f[13:11]};
            8'h98: return f[7:0];
            default: return 8'h00;
        endcase
    endfunction

    // clear bits spread onto flag positions; vendor shares the mpeg clear
    function automatic logic [21:0] clr_map(input logic [20:0] c);
        return {c[20:14], c[20], c[13:0]};
    endfunction

    task automatic check(input logic [21:0] seen_v, input logic [21:0] exp_v);
        n_checks++;
        if (seen_v !== exp_v) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one read compared with the model
    task automatic rd_chk(input logic [7:0] a);
        resl_host_inst.access(1'b0, a, 8'h00, got, seen);
        check({21'h0, seen}, 22'h1);
        check({14'h0, got}, {14'h0, exp_rd(model, a)});
    endtask

    // events and clears for one cycle, a read of 0x89, a stray write, then reads of the other bytes
    task automatic step(input logic [21:0] e, input logic [20:0] c, input logic [21:0] m);
        logic [7:0] wa;
        evt = e;
        clr = c;
        mask = m;
        model = e | (model & ~clr_map(c));
        @(posedge clk);
        #1 evt = '0;
        clr = '0;
        rd_chk(8'h89);
        wa = exp_rd(22'h3fffff, 8'h89) == 8'h00 ? 8'h00 : 8'h89;
        resl_host_inst.access(1'b1, ($urandom % 2) ? wa : 8'h98, 8'($urandom), got, seen);
        check({21'h0, seen}, 22'h1);
        rd_chk(8'h8e);
        rd_chk(8'h97);
        rd_chk(8'h98);
        rd_chk(8'($urandom));
        check(valid, resl_host_inst.heed(model, mask));
        check({21'h0, any_valid}, {21'h0, |resl_host_inst.heed(model, mask)});
    endtask

    // reset, corner cases, then random traffic
    initial begin
        nrst = 1'b0;
        evt = '0;
        clr = '0;
        mask = '0;
        model = '0;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(32'h3bfac9a3));
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        step(22'h0, 21'h0, 22'h3fffff);
        step(22'h3fffff, 21'h0, 22'h3fffff);
        step(22'h3fffff, 21'h1fffff, 22'h3fffff);
        step(22'h0, 21'h0fffff, 22'h2aaaaa);
        step(22'h0, 21'h1fffff, 22'h3fffff);
        step(22'h004000, 21'h100000, 22'h3fffff);
        // second reset in mid-run with every flag set; all must read zero after it
        step(22'h3fffff, 21'h0, 22'h3fffff);
        nrst = 1'b0;
        model = '0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        step(22'h0, 21'h0, 22'h3fffff);
        for (it = 0; it < 300; it++) begin
            step(22'($urandom & $urandom & $urandom), 21'($urandom & $urandom & $urandom), 22'($urandom | $urandom));
        end
        wrap_up;
    end

    // watchdog
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
endmodule
